// [core/host_byte_port.sv]
// controller side of the host byte port: command/status and data ports,
// flags, command engine, burst timing and pulsed host interrupt
// assumes host strobes and bus arrive asynchronously on pins and that
// config and event ports come from logic on clk_in
`timescale 1ns/100ps
// Operation
// [RQ1] host interrupt is a pulse, never a held level
// [RQ2] host takes the pulse on an unshared event input as an edge
// [RQ3] pulse when the input-full flag drops after a byte is taken
// [RQ4] pulse when a byte is loaded and the output-full flag rises
// [RQ5] internal event sets pending-event flag and pulses; pulses only when the flag rises, none for an event queued while it is set
// [RQ6] host answers the pending-event flag with the query command
// [RQ7] read: pulse on command taken, none on address, pulse on data
// [RQ8] write: pulse as each of command, address and data is taken
// [RQ9] query: no pulse on command, pulse when value is loaded
// [RQ10] burst on: no pulse on command, pulse when ack loaded
// [RQ11] burst off: pulse when command is taken and input-full clears
// [RQ12] host gains ownership of the interface before any exchange
// [RQ13] each transaction is a command byte then command-specific data
// [RQ14] host write to either port sets input-full within 1 us
// [RQ15] input-full clears when the engine takes the byte
// [RQ16] output-full sets when the engine loads the output byte
// [RQ17] output-full clears when the host reads the data port
// [RQ18] command/status and data ports decode at configurable addresses
// [RQ19] codes: read 80, write 81, burst on 82, off 83, query 84
// [RQ20] entering burst sets burst bit, loads 90, sets output-full, pulses
// [RQ21] query value zero only means no event outstanding
// [RQ22] burst ends after 400 us first, 50 us later, 1 ms total
// [RQ23] one pulse of programmable width per event, idle gap between
// [RQ24] status read returns flags and changes none of them
module host_byte_port #(
  parameter int ADDR_W = 16,
  parameter int unsigned BURST_FIRST_CYCLES =
    ec_port_pkg::BURST_FIRST_CYCLES,
  parameter int unsigned BURST_NEXT_CYCLES = ec_port_pkg::BURST_NEXT_CYCLES,
  parameter int unsigned BURST_TOTAL_CYCLES =
    ec_port_pkg::BURST_TOTAL_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // host bus pins
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic host_wr_n_in,
  input wire logic host_rd_n_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  output logic host_rdata_oe_out,
  // configuration
  input wire logic [ADDR_W-1:0] command_status_port_addr_in,
  input wire logic [ADDR_W-1:0] data_port_addr_in,
  input wire logic [7:0] pulse_width_in,
  // internal event source
  input wire logic event_valid_in,
  input wire logic [7:0] event_code_in,
  output logic event_ready_out,
  // host interrupt and status
  output logic host_event_interrupt_out,
  output logic input_full_flag_out,
  output logic output_full_flag_out,
  output logic burst_active_out,
  output logic pending_event_flag_out
);
  // synchronisers; bit 0 first flop, bit 2 previous
  logic [2:0] wr_n_sync;
  logic [2:0] rd_n_sync;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [7:0] wdata_s1;
  logic [7:0] wdata_s2;
  logic hit_cmd;
  logic hit_data;
  logic wr_evt;
  logic rd_fall;
  logic rd_data_evt;
  logic host_access;

  // buffers and engine
  logic [7:0] ibuf_byte;
  logic ibuf_is_cmd;
  logic [7:0] obuf_byte;
  logic [7:0] status_byte;
  logic [7:0] ec_space [256];
  logic [7:0] mem_addr;
  logic [7:0] resp_byte;
  logic resp_burst;
  ec_port_pkg::eng_state_t eng_state;
  ec_port_pkg::eng_state_t next_state;
  logic [7:0] next_resp;
  logic next_resp_burst;
  logic consume;
  logic eng_pulse;
  logic pop_event;
  logic mem_we;
  logic addr_load;
  logic obuf_load;
  logic burst_off_cmd;

  // events, burst timing and pulse shaper
  logic ev_valid;
  logic [7:0] ev_code;
  logic ev_flag_q;
  logic ev_rise;
  logic burst_first;
  logic [31:0] gap_cnt;
  logic [31:0] total_cnt;
  logic burst_timeout;
  logic [3:0] pend_pulses;
  logic pulse_take;
  logic [7:0] pulse_cnt;
  logic [7:0] width_m1;
  ec_port_pkg::pulse_state_t pulse_state;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_n_sync <= 3'b111;
      rd_n_sync <= 3'b111;
      addr_s1 <= '0;
      addr_s2 <= '0;
      wdata_s1 <= ec_port_pkg::BYTE_RST;
      wdata_s2 <= ec_port_pkg::BYTE_RST;
    end else begin
      wr_n_sync <= {wr_n_sync[1:0], host_wr_n_in};
      rd_n_sync <= {rd_n_sync[1:0], host_rd_n_in};
      addr_s1 <= host_addr_in;
      addr_s2 <= addr_s1;
      wdata_s1 <= host_wdata_in;
      wdata_s2 <= wdata_s1;
    end
  end

  // port decode; bus stable while strobe low
  assign hit_cmd = (addr_s2 == command_status_port_addr_in); // [RQ18]
  assign hit_data = (addr_s2 == data_port_addr_in); // [RQ18]
  assign wr_evt = wr_n_sync[2] & ~wr_n_sync[1] & (hit_cmd | hit_data);
  assign rd_fall = rd_n_sync[2] & ~rd_n_sync[1];
  assign rd_data_evt = rd_fall & hit_data;
  assign host_access = wr_evt | (rd_fall & (hit_cmd | hit_data));

  // status byte, reserved bits zero
  always_comb begin
    status_byte = '0;
    status_byte[ec_port_pkg::ST_OBF_BIT] = output_full_flag_out;
    status_byte[ec_port_pkg::ST_IBF_BIT] = input_full_flag_out;
    status_byte[ec_port_pkg::ST_CMD_BIT] = ibuf_is_cmd;
    status_byte[ec_port_pkg::ST_BURST_BIT] = burst_active_out;
    status_byte[ec_port_pkg::ST_EVT_BIT] = pending_event_flag_out;
  end

  // input buffer: host write sets, engine take clears, set wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ibuf_byte <= ec_port_pkg::BYTE_RST;
      ibuf_is_cmd <= 1'b0;
      input_full_flag_out <= 1'b0;
    end else begin
      if (wr_evt) begin
        ibuf_byte <= wdata_s2;
        ibuf_is_cmd <= hit_cmd; // [RQ13]
        input_full_flag_out <= 1'b1; // [RQ14]
      end else if (consume) begin
        input_full_flag_out <= 1'b0; // [RQ15]
      end
    end
  end

  // output buffer: engine load sets, host data read clears, set wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      obuf_byte <= ec_port_pkg::BYTE_RST;
      output_full_flag_out <= 1'b0;
    end else begin
      if (obuf_load) begin
        obuf_byte <= resp_byte;
        output_full_flag_out <= 1'b1; // [RQ16]
      end else if (rd_data_evt) begin
        output_full_flag_out <= 1'b0; // [RQ17]
      end
    end
  end

  // read data; a status read only samples the flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_rdata_out <= ec_port_pkg::BYTE_RST;
      host_rdata_oe_out <= 1'b0;
    end else begin
      host_rdata_oe_out <= ~rd_n_sync[1] & (hit_cmd | hit_data);
      if (rd_fall & hit_cmd) begin
        host_rdata_out <= status_byte; // [RQ24]
      end else if (rd_data_evt) begin
        host_rdata_out <= obuf_byte;
      end
    end
  end

  // engine decode; a held answer blocks new bytes
  always_comb begin
    consume = input_full_flag_out && (eng_state != ec_port_pkg::ENG_RESPOND);
    next_state = eng_state;
    next_resp = resp_byte;
    next_resp_burst = resp_burst;
    eng_pulse = 1'b0;
    pop_event = 1'b0;
    mem_we = 1'b0;
    addr_load = 1'b0;
    obuf_load = 1'b0;
    burst_off_cmd = 1'b0;
    if (eng_state == ec_port_pkg::ENG_RESPOND) begin
      if (!output_full_flag_out) begin
        obuf_load = 1'b1;
        eng_pulse = 1'b1; // [RQ4]
        next_state = ec_port_pkg::ENG_IDLE;
      end
    end else if (consume && ibuf_is_cmd) begin
      next_resp_burst = 1'b0;
      case (ibuf_byte) // [RQ19]
        ec_port_pkg::CMD_READ: begin
          eng_pulse = 1'b1; // [RQ7] [RQ3]
          next_state = ec_port_pkg::ENG_RD_ADDR;
        end
        ec_port_pkg::CMD_WRITE: begin
          eng_pulse = 1'b1; // [RQ8] [RQ3]
          next_state = ec_port_pkg::ENG_WR_ADDR;
        end
        ec_port_pkg::CMD_BURST_ON: begin
          next_resp = ec_port_pkg::BURST_ACK; // [RQ10]
          next_resp_burst = 1'b1;
          next_state = ec_port_pkg::ENG_RESPOND;
        end
        ec_port_pkg::CMD_BURST_OFF: begin
          eng_pulse = 1'b1; // [RQ11]
          burst_off_cmd = 1'b1;
          next_state = ec_port_pkg::ENG_IDLE;
        end
        ec_port_pkg::CMD_QUERY: begin
          // zero is kept for the empty case only
          next_resp = ev_valid ? ev_code : ec_port_pkg::NO_EVENT; // [RQ21]
          pop_event = ev_valid; // [RQ9]
          next_state = ec_port_pkg::ENG_RESPOND;
        end
        default: begin
          eng_pulse = 1'b1; // [RQ3]
          next_state = ec_port_pkg::ENG_IDLE;
        end
      endcase
    end else if (consume) begin
      case (eng_state)
        ec_port_pkg::ENG_RD_ADDR: begin
          next_resp = ec_space[ibuf_byte]; // [RQ7]
          next_state = ec_port_pkg::ENG_RESPOND;
        end
        ec_port_pkg::ENG_WR_ADDR: begin
          addr_load = 1'b1;
          eng_pulse = 1'b1; // [RQ8]
          next_state = ec_port_pkg::ENG_WR_DATA;
        end
        ec_port_pkg::ENG_WR_DATA: begin
          mem_we = 1'b1;
          eng_pulse = 1'b1; // [RQ8]
          next_state = ec_port_pkg::ENG_IDLE;
        end
        default: begin
          eng_pulse = 1'b1; // [RQ3]
          next_state = ec_port_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // engine state and held answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eng_state <= ec_port_pkg::ENG_IDLE;
      resp_byte <= ec_port_pkg::BYTE_RST;
      resp_burst <= 1'b0;
      mem_addr <= ec_port_pkg::BYTE_RST;
    end else begin
      eng_state <= next_state;
      resp_byte <= next_resp;
      resp_burst <= next_resp_burst;
      if (addr_load) begin
        mem_addr <= ibuf_byte;
      end
    end
  end

  // controller address space, contents undefined after power-up
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      ec_space[mem_addr] <= ibuf_byte;
    end
  end

  // burst mode: set with the ack load, ends on command or timeout
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      burst_active_out <= 1'b0;
    end else if (obuf_load && resp_burst) begin
      burst_active_out <= 1'b1; // [RQ20]
    end else if (burst_off_cmd || burst_timeout) begin
      burst_active_out <= 1'b0; // [RQ22]
    end
  end

  // burst watchdogs, 32-bit counters
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      burst_first <= 1'b1;
      gap_cnt <= '0;
      total_cnt <= '0;
    end else if (!burst_active_out || burst_timeout) begin
      burst_first <= 1'b1;
      gap_cnt <= '0;
      total_cnt <= '0;
    end else begin
      total_cnt <= total_cnt + 32'd1;
      if (host_access) begin
        burst_first <= 1'b0;
        gap_cnt <= '0;
      end else begin
        gap_cnt <= gap_cnt + 32'd1;
      end
    end
  end

  // timeout also counts as an event the host must be told of
  assign burst_timeout = burst_active_out && !burst_off_cmd &&
    ((burst_first && gap_cnt >= 32'(BURST_FIRST_CYCLES)) ||
     (!burst_first && gap_cnt >= 32'(BURST_NEXT_CYCLES)) ||
     total_cnt >= 32'(BURST_TOTAL_CYCLES)); // [RQ22]

  // event codes queue here so a busy query path loses none
  two_entry_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) event_queue (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(event_valid_in & (event_code_in != ec_port_pkg::NO_EVENT)),
    .in_data_in(event_code_in),
    .in_ready_out(event_ready_out),
    .out_valid_out(ev_valid),
    .out_data_out(ev_code),
    .out_ready_in(pop_event)
  );

  // pending flag is a non-empty queue; its rise asks a pulse
  assign pending_event_flag_out = ev_valid; // [RQ5]
  assign ev_rise = ev_valid & ~ev_flag_q; // [RQ5]

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_flag_q <= 1'b0;
    end else begin
      ev_flag_q <= ev_valid;
    end
  end

  // queued requests, so close events each get a pulse
  assign pulse_take = (pulse_state == ec_port_pkg::P_IDLE) &&
    (pend_pulses != '0);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_pulses <= ec_port_pkg::PULSES_RST;
    end else begin
      pend_pulses <= pend_pulses + 4'(eng_pulse) + 4'(ev_rise) +
        4'(burst_timeout) - 4'(pulse_take); // [RQ23]
    end
  end

  // width of zero is treated as one cycle
  assign width_m1 = (pulse_width_in == 8'h00) ? 8'h00 : pulse_width_in - 8'h01;

  // pulse shaper: high for the width, then low for at least the width plus one idle cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_state <= ec_port_pkg::P_IDLE;
      pulse_cnt <= ec_port_pkg::BYTE_RST;
      host_event_interrupt_out <= 1'b0;
    end else begin
      case (pulse_state)
        ec_port_pkg::P_IDLE: begin
          if (pulse_take) begin
            host_event_interrupt_out <= 1'b1; // [RQ1]
            pulse_cnt <= width_m1;
            pulse_state <= ec_port_pkg::P_HIGH;
          end
        end
        ec_port_pkg::P_HIGH: begin
          if (pulse_cnt == 8'h00) begin
            host_event_interrupt_out <= 1'b0; // [RQ1] [RQ23]
            pulse_cnt <= width_m1;
            pulse_state <= ec_port_pkg::P_GAP;
          end else begin
            pulse_cnt <= pulse_cnt - 8'h01;
          end
        end
        ec_port_pkg::P_GAP: begin
          if (pulse_cnt == 8'h00) begin
            pulse_state <= ec_port_pkg::P_IDLE; // [RQ23]
          end else begin
            pulse_cnt <= pulse_cnt - 8'h01;
          end
        end
        default: begin
          host_event_interrupt_out <= 1'b0;
          pulse_state <= ec_port_pkg::P_IDLE;
        end
      endcase
    end
  end

endmodule

// [core/ec_port_pkg.sv]
// constants shared by the host byte port and its test bench
// assumes a single controller clock at the rate given below
package ec_port_pkg;

  // command byte codes written to the command/status port
  localparam logic [7:0] CMD_READ = 8'h80;
  localparam logic [7:0] CMD_WRITE = 8'h81;
  localparam logic [7:0] CMD_BURST_ON = 8'h82;
  localparam logic [7:0] CMD_BURST_OFF = 8'h83;
  localparam logic [7:0] CMD_QUERY = 8'h84;

  // fixed answer bytes
  localparam logic [7:0] BURST_ACK = 8'h90;
  localparam logic [7:0] NO_EVENT = 8'h00;

  // status byte field positions, other bits read as zero
  localparam int ST_OBF_BIT = 0;
  localparam int ST_IBF_BIT = 1;
  localparam int ST_CMD_BIT = 3;
  localparam int ST_BURST_BIT = 4;
  localparam int ST_EVT_BIT = 5;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] PULSES_RST = 4'h0;

  // clock rate and documented times
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned IBF_SET_MAX_NS = 1000;
  localparam int unsigned BURST_FIRST_US = 400;
  localparam int unsigned BURST_NEXT_US = 50;
  localparam int unsigned BURST_TOTAL_US = 1000;

  // longest times round down to whole cycles
  localparam int unsigned IBF_SET_MAX_CYCLES = IBF_SET_MAX_NS * CLK_MHZ / 1000;
  localparam int unsigned BURST_FIRST_CYCLES = BURST_FIRST_US * CLK_MHZ;
  localparam int unsigned BURST_NEXT_CYCLES = BURST_NEXT_US * CLK_MHZ;
  localparam int unsigned BURST_TOTAL_CYCLES = BURST_TOTAL_US * CLK_MHZ;

  // command engine and interrupt pulse states
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_RD_ADDR, ENG_WR_ADDR, ENG_WR_DATA, ENG_RESPOND
  } eng_state_t;

  typedef enum logic [1:0] {P_IDLE, P_HIGH, P_GAP} pulse_state_t;

endpackage

// [core/two_entry_buffer.sv]
// small valid/ready buffer holding event codes for the query command
// assumes both sides run on the same clock
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data_out = slots[rd_ptr];

  // occupancy; ready and valid are flops so full and empty are exact
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_out <= (next_count != CW'(DEPTH));
      out_valid_out <= (next_count != '0);
    end
  end

  // pointers wrap at the last slot
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // storage needs no reset, valid guards it
  always_ff @(posedge clk_in) begin
    if (push) begin
      slots[wr_ptr] <= in_data_in;
    end
  end

endmodule

// [testbench/host_byte_port_props.sv]
// checker on the host byte port's top-level ports
// assumes one clock and a pulse width of two cycles from the bench
`timescale 1ns/100ps
module host_byte_port_props #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // host bus pins
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic host_wr_n_in,
  input wire logic host_rd_n_in,
  input wire logic host_rdata_oe_out,
  // configuration
  input wire logic [ADDR_W-1:0] command_status_port_addr_in,
  input wire logic [ADDR_W-1:0] data_port_addr_in,
  input wire logic [7:0] pulse_width_in,
  // event source
  input wire logic event_valid_in,
  input wire logic [7:0] event_code_in,
  input wire logic event_ready_out,
  // interrupt and status
  input wire logic host_event_interrupt_out,
  input wire logic input_full_flag_out,
  input wire logic output_full_flag_out,
  input wire logic burst_active_out,
  input wire logic pending_event_flag_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // host address hits a port
  logic port_hit;
  assign port_hit = (host_addr_in == command_status_port_addr_in) ||
    (host_addr_in == data_port_addr_in);

  // width high, then gap and one idle cycle
  sequence s_high;
    host_event_interrupt_out [*2];
  endsequence
  sequence s_gap;
    !host_event_interrupt_out [*3];
  endsequence

  property p_pulse_shape;
    $rose(host_event_interrupt_out) && pulse_width_in == 8'h02 |->
      s_high ##1 s_gap;
  endproperty
  a_pulse_shape: assert property (p_pulse_shape)
    else $error("bad pulse shape");

  // four cycles, well inside 1 us
  property p_ibf_set;
    $fell(host_wr_n_in) && port_hit |-> ##[1:4] input_full_flag_out;
  endproperty
  a_ibf_set: assert property (p_ibf_set)
    else $error("input full not set");

  property p_ibf_cause;
    $rose(input_full_flag_out) |-> !$past(host_wr_n_in);
  endproperty
  a_ibf_cause: assert property (p_ibf_cause)
    else $error("input full rose unasked");

  property p_ibf_taken;
    $rose(input_full_flag_out) |-> ##[1:40] !input_full_flag_out;
  endproperty
  a_ibf_taken: assert property (p_ibf_taken)
    else $error("input byte never taken");

  property p_obf_clear;
    output_full_flag_out && $fell(host_rd_n_in) &&
      host_addr_in == data_port_addr_in |->
      ##[1:5] !output_full_flag_out && host_rdata_oe_out;
  endproperty
  a_obf_clear: assert property (p_obf_clear)
    else $error("output full not cleared");

  property p_obf_pulse;
    $rose(output_full_flag_out) |-> ##[1:40] host_event_interrupt_out;
  endproperty
  a_obf_pulse: assert property (p_obf_pulse)
    else $error("no pulse on output load");

  property p_evt_take;
    event_valid_in && event_ready_out && event_code_in != 8'h00 |=>
      pending_event_flag_out;
  endproperty
  a_evt_take: assert property (p_evt_take)
    else $error("pending event flag not set");

  property p_evt_pulse;
    $rose(pending_event_flag_out) |-> ##[1:40] host_event_interrupt_out;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("no pulse for pending event");

  property p_burst_ack;
    $rose(burst_active_out) |-> ##[0:2] output_full_flag_out;
  endproperty
  a_burst_ack: assert property (p_burst_ack)
    else $error("burst without ack byte");

  property p_burst_exit;
    $fell(burst_active_out) |-> ##[1:40] host_event_interrupt_out;
  endproperty
  a_burst_exit: assert property (p_burst_exit)
    else $error("burst exit without pulse");
endmodule

bind host_byte_port host_byte_port_props #(.ADDR_W(ADDR_W)) props_inst (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .host_addr_in(host_addr_in),
  .host_wr_n_in(host_wr_n_in), .host_rd_n_in(host_rd_n_in),
  .host_rdata_oe_out(host_rdata_oe_out),
  .command_status_port_addr_in(command_status_port_addr_in),
  .data_port_addr_in(data_port_addr_in), .pulse_width_in(pulse_width_in),
  .event_valid_in(event_valid_in), .event_code_in(event_code_in),
  .event_ready_out(event_ready_out),
  .host_event_interrupt_out(host_event_interrupt_out),
  .input_full_flag_out(input_full_flag_out),
  .output_full_flag_out(output_full_flag_out),
  .burst_active_out(burst_active_out),
  .pending_event_flag_out(pending_event_flag_out));

// [testbench/host_model.sv]
// host processor model driving the byte port pins
// assumes it is the sole owner of the interface, no lock needed
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk_in,
  // host bus pins
  output logic [15:0] host_addr_out,
  output logic host_wr_n_out,
  output logic host_rd_n_out,
  output logic [7:0] host_wdata_out,
  input wire logic [7:0] host_rdata_in
);
  // idle bus, strobes high
  initial begin
    host_addr_out = 16'h0000;
    host_wr_n_out = 1'b1;
    host_rd_n_out = 1'b1;
    host_wdata_out = 8'h00;
  end

  // strobe low four cycles; released lines invert
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    host_addr_out <= a;
    host_wdata_out <= d;
    host_wr_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    host_wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    host_wdata_out <= ~d;
    host_addr_out <= ~a;
  endtask

  // data taken late in the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    host_addr_out <= a;
    host_rd_n_out <= 1'b0;
    repeat (5) @(posedge clk_in);
    d = host_rdata_in;
    host_rd_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    host_addr_out <= ~a;
  endtask
endmodule

// [testbench/host_byte_port_test.sv]
// self-checking bench for the host byte port
// assumes the host model and a two-cycle pulse width
`timescale 1ns/100ps
module host_byte_port_test;
  localparam logic [15:0] CS = 16'h0066;
  localparam logic [15:0] DP = 16'h0062;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] host_addr;
  logic host_wr_n, host_rd_n, host_oe, irq, irq_q, input_full_flag, output_full_flag, burst, pend;
  logic [7:0] host_wdata, host_rdata, rd_val;
  logic event_valid_in = 1'b0;
  logic [7:0] event_code_in = 8'h00;
  logic event_ready;
  int pulses = 0;
  int checks = 0;
  int fail_count = 0;

  always #2 clk_in = ~clk_in;

  host_model host_model_inst (.clk_in(clk_in), .host_addr_out(host_addr),
    .host_wr_n_out(host_wr_n), .host_rd_n_out(host_rd_n),
    .host_wdata_out(host_wdata), .host_rdata_in(host_rdata));

  // short burst limits
  host_byte_port #(.BURST_FIRST_CYCLES(400), .BURST_NEXT_CYCLES(200),
    .BURST_TOTAL_CYCLES(1000)) host_byte_port_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .host_addr_in(host_addr),
    .host_wr_n_in(host_wr_n), .host_rd_n_in(host_rd_n),
    .host_wdata_in(host_wdata), .host_rdata_out(host_rdata),
    .host_rdata_oe_out(host_oe), .command_status_port_addr_in(CS),
    .data_port_addr_in(DP), .pulse_width_in(8'h02),
    .event_valid_in(event_valid_in), .event_code_in(event_code_in),
    .event_ready_out(event_ready), .host_event_interrupt_out(irq),
    .input_full_flag_out(input_full_flag), .output_full_flag_out(output_full_flag),
    .burst_active_out(burst), .pending_event_flag_out(pend));

  // count rising edges; a level counts once
  always @(posedge clk_in) begin
    irq_q <= irq;
    if (irq === 1'b1 && irq_q !== 1'b1) pulses <= pulses + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string msg);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // one write, then count its pulses
  task automatic byte_wr(input logic [15:0] a, input logic [7:0] d,
      input int n, input string msg);
    int p0;
    p0 = pulses;
    host_model_inst.wr(a, d);
    repeat (25) @(posedge clk_in);
    check(8'(pulses - p0), 8'(n), msg);
  endtask

  task automatic offer(input logic [7:0] c);
    int n = 0;
    @(posedge clk_in);
    event_valid_in <= 1'b1;
    event_code_in <= c;
    do begin
      @(posedge clk_in);
      n++;
    end while (event_ready !== 1'b1 && n < 16);
    event_valid_in <= 1'b0;
  endtask

  task automatic t_write;
    byte_wr(CS, ec_port_pkg::CMD_WRITE, 1, "write cmd pulse");
    byte_wr(DP, 8'h12, 1, "write addr pulse");
    byte_wr(DP, 8'ha5, 1, "write data pulse");
    check(8'(input_full_flag), 8'h00, "input full left set");
  endtask

  task automatic t_read;
    byte_wr(CS, ec_port_pkg::CMD_READ, 1, "read cmd pulse");
    byte_wr(DP, 8'h12, 1, "read addr one pulse");
    check(8'(output_full_flag), 8'h01, "output full not set");
    host_model_inst.rd(CS, rd_val);
    check(rd_val & 8'h33, 8'h01, "status after load");
    check(8'(output_full_flag), 8'h01, "status read cleared flag");
    host_model_inst.rd(DP, rd_val);
    check(rd_val, 8'ha5, "read data wrong");
    check(8'(output_full_flag), 8'h00, "output full not cleared");
  endtask

  task automatic t_burst;
    int p0;
    byte_wr(CS, ec_port_pkg::CMD_BURST_ON, 1, "burst on pulse");
    check(8'(burst), 8'h01, "burst not entered");
    host_model_inst.rd(CS, rd_val);
    check(rd_val & 8'h11, 8'h11, "burst status");
    host_model_inst.rd(DP, rd_val);
    check(rd_val, ec_port_pkg::BURST_ACK, "burst ack byte");
    byte_wr(CS, ec_port_pkg::CMD_BURST_OFF, 1, "burst off pulse");
    check(8'(burst), 8'h00, "burst not left");
    byte_wr(CS, ec_port_pkg::CMD_BURST_ON, 1, "burst again");
    host_model_inst.rd(DP, rd_val);
    p0 = pulses;
    repeat (250) @(posedge clk_in);
    check(8'(burst), 8'h00, "burst timeout missed");
    check(8'(pulses - p0), 8'h01, "burst timeout pulse");
  endtask

  // query, then queue filled and drained
  task automatic query(input logic [7:0] exp, input string msg);
    byte_wr(CS, ec_port_pkg::CMD_QUERY, 1, msg);
    host_model_inst.rd(DP, rd_val);
    check(rd_val, exp, msg);
  endtask

  task automatic t_event;
    int p0;
    p0 = pulses;
    offer(8'h3c);
    repeat (25) @(posedge clk_in);
    check(8'(pend), 8'h01, "pending flag");
    check(8'(pulses - p0), 8'h01, "event pulse");
    query(8'h3c, "query value");
    check(8'(pend), 8'h00, "pending left set");
    query(ec_port_pkg::NO_EVENT, "empty query");
    offer(8'h41);
    offer(8'h42);
    repeat (2) @(posedge clk_in);
    check(8'(event_ready), 8'h00, "queue full not refused");
    repeat (25) @(posedge clk_in);
    query(8'h41, "queue head");
    query(8'h42, "queue second");
    check(8'(pend), 8'h00, "queue not empty");
  endtask

  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // run is under a thousand cycles
  initial begin
    #(4 * 20000);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    byte_wr(16'h0070, ec_port_pkg::CMD_WRITE, 0, "stray address");
    t_write();
    t_read();
    t_burst();
    t_event();
    summarize();
  end
endmodule
